// >>> hdl/pcc_regs.vh
/*
 Constants for the primary cache controller: register offsets, field
 positions, reset values, operation codes and refill timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef PCC_REGS_VH
`define PCC_REGS_VH

// Register word offsets (byte address = 4 * index)
`define PCC_CFG_IDX       4'h0
`define PCC_TAG_IDX       4'h1
`define PCC_OP_IDX        4'h2
`define PCC_OPADDR_IDX    4'h3
`define PCC_STAT_IDX      4'h4
`define PCC_OPDONE_IDX    4'h5

// Config fields
`define PCC_CFG_IDIS_BIT  0
`define PCC_CFG_DDIS_BIT  1
`define PCC_CFG_WT_BIT    2
`define PCC_CFG_RST       32'h0000_0000

// Tag staging fields: tag[23:0], wb 24, lock 25, state 27:26
`define PCC_TG_WB_BIT     24
`define PCC_TG_LOCK_BIT   25
`define PCC_TG_CS_LO      26
`define PCC_CS_VALID      2'h3
`define PCC_CS_INVALID    2'h0

// Operation register: [3:0] op code, bit 4 selects data cache
`define PCC_OP_DSEL_BIT   4
`define PCC_OP_IDX_INV    4'h0
`define PCC_OP_IDX_LDTAG  4'h1
`define PCC_OP_IDX_STTAG  4'h2
`define PCC_OP_CREATE_DE  4'h3
`define PCC_OP_HIT_INV    4'h4
`define PCC_OP_HIT_WBINV  4'h5
`define PCC_OP_FILL       4'h6
`define PCC_OP_HIT_WB     4'h7
`define PCC_OP_IDX_WBINV  4'h8

// Refill timing in cycles
`define PCC_MEM_TO_BUS_CYC 4
`define PCC_BUS_TO_INT_CYC 2

`endif

// >>> hdl/pcc_top.v
/*
 Primary cache controller: tag arrays, maintenance operations, miss
 handling with refill, write buffer and write-through policy.
 Assumes an Avalon-MM master for software, a pipeline request port and
 a simple single-beat memory port that answers with mem_ack.
*/
// The register offsets and the Avalon-MM register port were chosen for this implementation.
// Behaviour
// - Separate disable bits for instruction and data caches.
// - Disabled cache always misses, no refill, tag state untouched.
// - Instruction fetch with cache off is one single-word read.
// - Data access with cache off is one single read or write.
// - Maintenance operations run even on a disabled cache.
// - Any reset clears every valid and state bit.
// - Index invalidate clears the indexed line of the selected cache, no tag check.
// - Index write-back invalidate writes back dirty line, then invalidates.
// - Index load tag copies indexed tag into the staging register.
// - Index store tag writes staging register into indexed tag.
// - Create dirty exclusive writes back dirty miss, sets tag, marks valid.
// - Hit invalidate clears a line only when it holds the address.
// - Hit write-back invalidate writes dirty hit line, then invalidates.
// - Hit write-back writes dirty hit line, keeps it valid and clean.
// - Fill loads the addressed line from memory.
// - Dirty lines reach memory only on replacement or write-back ops.
// - A written-back line becomes invalid, except after hit write-back.
// - Write-through stores update cache and memory together.
// - Refill starts at word zero and runs sequentially.
// - Load miss: dirty victim to buffer, refill, then drain.
// - Store miss: dirty victim buffered, merged line written, then drained.
// - Refill waits 2 bus-to-internal cycles after the last word; the 4-cycle memory-to-bus count is unused.
// - Victim: lowest invalid way first, else FIFO order from the pointer, never locked valid.
// - Dirty tracked by a separate write-back bit in the tag.
`timescale 1ns/1ps
`include "pcc_regs.vh"

module pcc_top #(
  parameter SETS_W = 8,
  parameter WORDS  = 4
) (
  input  wire        MCLK_I,
  input  wire        RST_N_I,
  input  wire [3:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  output reg  [31:0] AVS_READDATA_O,
  output wire        AVS_WAITREQUEST_O,
  input  wire        PIPE_REQ_I,
  input  wire        PIPE_DSEL_I,
  input  wire        PIPE_WE_I,
  input  wire [35:0] PIPE_ADDR_I,
  input  wire [31:0] PIPE_WDATA_I,
  output reg  [31:0] PIPE_RDATA_O,
  output wire        PIPE_STALL_O,
  output reg         MEM_REQ_O,
  output reg         MEM_WE_O,
  output reg  [35:0] MEM_ADDR_O,
  output reg  [31:0] MEM_WDATA_O,
  input  wire        MEM_ACK_I,
  input  wire [31:0] MEM_RDATA_I
);

  localparam SETS = 1 << SETS_W;
  localparam WW   = (WORDS > 1) ? $clog2(WORDS) : 1;
  localparam NL   = 2 * SETS * 4;
  localparam LW   = SETS_W + 3;

  localparam S_IDLE  = 4'h0;
  localparam S_LOOK  = 4'h1;
  localparam S_WBLD  = 4'h2;
  localparam S_FILL  = 4'h3;
  localparam S_LAT   = 4'h4;
  localparam S_DRAIN = 4'h5;
  localparam S_SGL   = 4'h6;
  localparam S_DONE  = 4'h7;

  // Line storage: cache select, set, way flattened to one index
  reg [23:0] tag_mem [0:NL-1];
  reg [31:0] dat_mem [0:NL*WORDS-1];
  reg [NL-1:0] vld_r;
  reg [NL-1:0] wb_r;
  reg [NL-1:0] lck_r;
  reg [1:0]  fifo_r [0:2*SETS-1];

  reg [31:0] cfg_r;
  reg [27:0] tagstg_r;
  reg [31:0] opaddr_r;
  reg [4:0]  op_r;
  reg        op_busy_r;
  reg        op_done_r;
  reg        av_ack_r;
  reg [3:0]  st_r;
  reg        from_op_r;
  reg        dsel_r;
  reg        we_r;
  reg [35:0] addr_r;
  reg [31:0] wdat_r;
  reg [3:0]  kind_r;
  reg [1:0]  way_r;
  reg [WW-1:0] cnt_r;
  reg [2:0]  lat_r;
  reg        inval_after_r;
  reg        refill_after_r;
  reg [31:0] wbuf_r [0:WORDS-1];
  reg [35:0] wbuf_a_r;
  reg        wbuf_v_r;

  integer i, j;

  wire [SETS_W-1:0] set_w = addr_r[5+SETS_W-1:5];
  wire [LW-1:0]     lbase = {dsel_r, set_w, 2'b00};
  wire [3:0]        vs = vld_r[lbase +: 4];
  wire [3:0]        ls = lck_r[lbase +: 4];
  wire [1:0]        fifo_cur = fifo_r[{dsel_r, set_w}];
  wire [1:0]        pick_way;
  wire              pick_ok;
  reg  [3:0]        hit_v;
  reg  [1:0]        hit_way;
  wire              hit = |hit_v;
  wire              cdis = dsel_r ? cfg_r[`PCC_CFG_DDIS_BIT] : cfg_r[`PCC_CFG_IDIS_BIT];
  wire [LW-1:0]     lhit = lbase + {{(LW-2){1'b0}}, hit_way};
  wire [LW-1:0]     lvic = lbase + {{(LW-2){1'b0}}, way_r};
  wire [LW-1:0]     lidx = lbase + {{(LW-2){1'b0}}, addr_r[13:12]};

  pcc_way_pick u_pick (
    .valid_i (vs),
    .lock_i  (ls & vs),
    .fifo_i  (fifo_cur),
    .way_o   (pick_way),
    .ok_o    (pick_ok)
  );

  always @* begin
    hit_way = 2'd0;
    for (j = 0; j < 4; j = j + 1) begin
      hit_v[j] = vs[j] && (tag_mem[lbase + j[LW-1:0]] == addr_r[35:12]);
    end
    // Multi-hit resolves to the lowest way
    for (j = 3; j >= 0; j = j - 1) begin
      if (hit_v[j]) begin
        hit_way = j[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: writes take one cycle, except op writes while an operation is busy; reads wait one cycle for data
  wire av_acc = AVS_READ_I | AVS_WRITE_I;
  // Operation start blocks while a previous one runs
  wire op_wr  = AVS_WRITE_I && (AVS_ADDRESS_I == `PCC_OP_IDX);
  assign AVS_WAITREQUEST_O = av_acc && (AVS_READ_I ? !av_ack_r : (op_wr && op_busy_r));

  wire op_go = op_busy_r && (st_r == S_IDLE);
  // Pipeline requests wait for any running maintenance operation
  wire pipe_go = PIPE_REQ_I && !op_busy_r && (st_r == S_IDLE);
  assign PIPE_STALL_O = PIPE_REQ_I && !(st_r == S_DONE && !from_op_r);

  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      av_ack_r       <= 1'b0;
      AVS_READDATA_O <= 32'h0000_0000;
      cfg_r          <= `PCC_CFG_RST;
      opaddr_r       <= 32'h0000_0000;
      op_r           <= 5'h00;
      op_busy_r      <= 1'b0;
    end else begin
      av_ack_r <= AVS_READ_I && !av_ack_r;
      if (AVS_READ_I) begin
        case (AVS_ADDRESS_I)
          `PCC_CFG_IDX:    AVS_READDATA_O <= cfg_r;
          `PCC_TAG_IDX:    AVS_READDATA_O <= {4'h0, tagstg_r};
          `PCC_OP_IDX:     AVS_READDATA_O <= {27'h0, op_r};
          `PCC_OPADDR_IDX: AVS_READDATA_O <= opaddr_r;
          `PCC_STAT_IDX:   AVS_READDATA_O <= {24'h0, wbuf_v_r, op_done_r, op_busy_r, st_r, 1'b0};
          default:         AVS_READDATA_O <= 32'h0000_0000;
        endcase
      end
      if (AVS_WRITE_I && !AVS_WAITREQUEST_O) begin
        case (AVS_ADDRESS_I)
          `PCC_CFG_IDX:    cfg_r <= {29'h0, AVS_WRITEDATA_I[2:0]};
          `PCC_OPADDR_IDX: opaddr_r <= AVS_WRITEDATA_I;
          `PCC_OP_IDX: begin
            op_r      <= AVS_WRITEDATA_I[4:0];
            op_busy_r <= 1'b1;
          end
          default: ;
        endcase
      end
      if (st_r == S_DONE && from_op_r) begin
        op_busy_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Controller
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= S_IDLE;
      vld_r <= {NL{1'b0}};
      wb_r  <= {NL{1'b0}};
      lck_r <= {NL{1'b0}};
      for (i = 0; i < 2*SETS; i = i + 1) begin
        fifo_r[i] <= 2'd0;
      end
      tagstg_r <= 28'h000_0000;
      op_done_r <= 1'b0;
      from_op_r <= 1'b0;
      dsel_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 36'h0_0000_0000;
      wdat_r <= 32'h0000_0000;
      kind_r <= 4'h0;
      way_r <= 2'd0;
      cnt_r <= {WW{1'b0}};
      lat_r <= 3'd0;
      inval_after_r <= 1'b0;
      refill_after_r <= 1'b0;
      wbuf_a_r <= 36'h0_0000_0000;
      wbuf_v_r <= 1'b0;
      MEM_REQ_O <= 1'b0;
      MEM_WE_O <= 1'b0;
      MEM_ADDR_O <= 36'h0_0000_0000;
      MEM_WDATA_O <= 32'h0000_0000;
      PIPE_RDATA_O <= 32'h0000_0000;
    end else begin
      if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `PCC_TAG_IDX) begin
        tagstg_r <= AVS_WRITEDATA_I[27:0];
      end
      if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `PCC_OPDONE_IDX) begin
        op_done_r <= 1'b0;
      end
      case (st_r)
        S_IDLE: begin
          if (op_go) begin
            from_op_r <= 1'b1;
            dsel_r <= op_r[`PCC_OP_DSEL_BIT];
            kind_r <= op_r[3:0];
            addr_r <= {4'h0, opaddr_r};
            we_r <= 1'b0;
            st_r <= S_LOOK;
          end else if (pipe_go) begin
            from_op_r <= 1'b0;
            dsel_r <= PIPE_DSEL_I;
            we_r <= PIPE_WE_I & PIPE_DSEL_I;
            addr_r <= PIPE_ADDR_I;
            wdat_r <= PIPE_WDATA_I;
            kind_r <= 4'hF;
            st_r <= S_LOOK;
          end
        end
        S_LOOK: begin
          inval_after_r <= 1'b0;
          refill_after_r <= 1'b0;
          cnt_r <= {WW{1'b0}};
          if (!from_op_r) begin
            if (cdis) begin
              st_r <= S_SGL;
              MEM_REQ_O <= 1'b1;
              MEM_WE_O <= we_r;
              MEM_ADDR_O <= addr_r;
              MEM_WDATA_O <= wdat_r;
            end else if (hit) begin
              PIPE_RDATA_O <= dat_mem[{lhit, addr_r[2+WW-1:2]}];
              if (we_r) begin
                dat_mem[{lhit, addr_r[2+WW-1:2]}] <= wdat_r;
                if (cfg_r[`PCC_CFG_WT_BIT]) begin
                  st_r <= S_SGL;
                  MEM_REQ_O <= 1'b1;
                  MEM_WE_O <= 1'b1;
                  MEM_ADDR_O <= addr_r;
                  MEM_WDATA_O <= wdat_r;
                end else begin
                  wb_r[lhit] <= 1'b1;
                  st_r <= S_DONE;
                end
              end else begin
                st_r <= S_DONE;
              end
            end else if (pick_ok) begin
              way_r <= pick_way;
              refill_after_r <= 1'b1;
              st_r <= S_WBLD;
            end else begin
              st_r <= S_SGL;
              MEM_REQ_O <= 1'b1;
              MEM_WE_O <= we_r;
              MEM_ADDR_O <= addr_r;
              MEM_WDATA_O <= wdat_r;
            end
          end else begin
            case (kind_r)
              `PCC_OP_IDX_INV: begin
                vld_r[lidx] <= 1'b0;
                st_r <= S_DONE;
              end
              `PCC_OP_IDX_WBINV: begin
                way_r <= addr_r[13:12];
                inval_after_r <= 1'b1;
                st_r <= S_WBLD;
              end
              `PCC_OP_IDX_LDTAG: begin
                tagstg_r <= {vld_r[lidx] ? `PCC_CS_VALID : `PCC_CS_INVALID,
                             lck_r[lidx], wb_r[lidx], tag_mem[lidx]};
                st_r <= S_DONE;
              end
              `PCC_OP_IDX_STTAG: begin
                tag_mem[lidx] <= tagstg_r[23:0];
                wb_r[lidx]  <= tagstg_r[`PCC_TG_WB_BIT];
                lck_r[lidx] <= tagstg_r[`PCC_TG_LOCK_BIT];
                vld_r[lidx] <= (tagstg_r[`PCC_TG_CS_LO+1:`PCC_TG_CS_LO] == `PCC_CS_VALID);
                st_r <= S_DONE;
              end
              `PCC_OP_HIT_INV: begin
                if (hit) begin
                  vld_r[lhit] <= 1'b0;
                end
                st_r <= S_DONE;
              end
              `PCC_OP_HIT_WBINV, `PCC_OP_HIT_WB: begin
                way_r <= hit_way;
                inval_after_r <= (kind_r == `PCC_OP_HIT_WBINV);
                st_r <= hit ? S_WBLD : S_DONE;
              end
              `PCC_OP_CREATE_DE, `PCC_OP_FILL: begin
                way_r <= hit ? hit_way : pick_way;
                refill_after_r <= (kind_r == `PCC_OP_FILL);
                st_r <= (hit ? (kind_r == `PCC_OP_CREATE_DE) : !pick_ok) ? S_DONE : S_WBLD;
              end
              default: st_r <= S_DONE;
            endcase
          end
        end
        S_WBLD: begin
          // write-back only on replace or op
          for (i = 0; i < WORDS; i = i + 1) begin
            wbuf_r[i] <= dat_mem[{lvic, i[WW-1:0]}];
          end
          wbuf_a_r <= {tag_mem[lvic], set_w[SETS_W-2:0], 5'h00};
          wbuf_v_r <= vld_r[lvic] && wb_r[lvic] && dsel_r;
          wb_r[lvic] <= 1'b0;
          if (inval_after_r) begin
            vld_r[lvic] <= 1'b0;
          end
          if (refill_after_r) begin
            vld_r[lvic] <= 1'b0;
            st_r <= S_FILL;
            MEM_REQ_O <= 1'b1;
            MEM_WE_O <= 1'b0;
            MEM_ADDR_O <= {addr_r[35:5], 5'h00};
          end else if (kind_r == `PCC_OP_CREATE_DE) begin
            tag_mem[lvic] <= addr_r[35:12];
            vld_r[lvic] <= 1'b1;
            wb_r[lvic] <= 1'b1;
            fifo_r[{dsel_r, set_w}] <= lvic[1:0] + 2'd1;
            st_r <= S_DRAIN;
          end else begin
            st_r <= S_DRAIN;
          end
        end
        S_FILL: begin
          if (MEM_ACK_I) begin
            dat_mem[{lvic, cnt_r}] <= MEM_RDATA_I;
            if (we_r && cnt_r == addr_r[2+WW-1:2]) begin
              dat_mem[{lvic, cnt_r}] <= wdat_r;
            end
            if (!we_r && cnt_r == addr_r[2+WW-1:2]) begin
              PIPE_RDATA_O <= MEM_RDATA_I;
            end
            if (cnt_r == WORDS[WW-1:0] - 1'b1) begin
              MEM_REQ_O <= 1'b0;
              lat_r <= 3'd0;
              st_r <= S_LAT;
            end else begin
              cnt_r <= cnt_r + 1'b1;
              MEM_ADDR_O <= MEM_ADDR_O + 36'h0_0000_0004;
            end
          end
        end
        S_LAT: begin
          lat_r <= lat_r + 3'd1;
          if (lat_r == `PCC_BUS_TO_INT_CYC - 1) begin
            tag_mem[lvic] <= addr_r[35:12];
            vld_r[lvic] <= 1'b1;
            wb_r[lvic] <= we_r && !cfg_r[`PCC_CFG_WT_BIT];
            lck_r[lvic] <= lck_r[lvic];
            fifo_r[{dsel_r, set_w}] <= lvic[1:0] + 2'd1;
            cnt_r <= {WW{1'b0}};
            st_r <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          if (!wbuf_v_r) begin
            // Write-through store miss still goes to memory
            if (we_r && cfg_r[`PCC_CFG_WT_BIT] && !from_op_r) begin
              we_r <= 1'b0;
              st_r <= S_SGL;
              MEM_REQ_O <= 1'b1;
              MEM_WE_O <= 1'b1;
              MEM_ADDR_O <= addr_r;
              MEM_WDATA_O <= wdat_r;
            end else begin
              st_r <= S_DONE;
            end
          end else if (!MEM_REQ_O) begin
            MEM_REQ_O <= 1'b1;
            MEM_WE_O <= 1'b1;
            MEM_ADDR_O <= wbuf_a_r;
            MEM_WDATA_O <= wbuf_r[0];
          end else if (MEM_ACK_I) begin
            if (cnt_r == WORDS[WW-1:0] - 1'b1) begin
              MEM_REQ_O <= 1'b0;
              MEM_WE_O <= 1'b0;
              wbuf_v_r <= 1'b0;
            end else begin
              cnt_r <= cnt_r + 1'b1;
              MEM_ADDR_O <= MEM_ADDR_O + 36'h0_0000_0004;
              MEM_WDATA_O <= wbuf_r[cnt_r + 1'b1];
            end
          end
        end
        S_SGL: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            MEM_WE_O <= 1'b0;
            if (!MEM_WE_O) begin
              PIPE_RDATA_O <= MEM_RDATA_I;
            end
            st_r <= S_DONE;
          end
        end
        S_DONE: begin
          if (from_op_r) begin
            op_done_r <= 1'b1;
          end
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

endmodule

// >>> hdl/pcc_way_pick.v
/*
 Victim way selection for one cache set.
 Assumes valid and lock bits of the four ways and the FIFO pointer.
*/
`timescale 1ns/1ps

module pcc_way_pick (
  input  wire [3:0] valid_i,
  input  wire [3:0] lock_i,
  input  wire [1:0] fifo_i,
  output reg  [1:0] way_o,
  output reg        ok_o
);

  integer k;
  reg [1:0] cand;

  always @* begin
    way_o = fifo_i;
    ok_o  = 1'b0;
    cand  = 2'd0;
    for (k = 3; k >= 0; k = k - 1) begin
      if (!valid_i[k]) begin
        way_o = k[1:0];
        ok_o  = 1'b1;
      end
    end
    if (!ok_o) begin
      for (k = 3; k >= 0; k = k - 1) begin
        cand = fifo_i + k[1:0];
        if (!lock_i[cand]) begin
          way_o = cand;
          ok_o  = 1'b1;
        end
      end
    end
  end

endmodule

// >>> verif/pcc_mem_model.sv
/*
 Memory behind the pcc_top memory port, answering each word after zero
 or two wait cycles in turn. Assumes one outstanding word at a time.
*/
`timescale 1ns/1ps

module pcc_mem_model (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        req_i,
  input  wire        we_i,
  input  wire [35:0] addr_i,
  input  wire [31:0] wdata_i,
  output reg         ack_o,
  output reg  [31:0] rdata_o
);
  logic [31:0] mem [logic [35:0]];
  logic [35:0] rd_log [int];
  int          n_rd = 0;
  int          n_wr = 0;
  int          wt = 0;
  bit          slow = 0;
  ////////////////////////////////////////
  // memory latency per word
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 32'h0000_0000;
      wt      <= 0;
    end else if (ack_o) begin
      ack_o   <= 1'b0;
      // Stale data must not pass for a fresh word
      rdata_o <= ~rdata_o;
    end else if (req_i && wt < (slow ? 2 : 0)) begin
      wt <= wt + 1;
    end else if (req_i) begin
      ack_o <= 1'b1;
      wt    <= 0;
      slow  <= !slow;
      if (we_i) begin
        mem[addr_i] = wdata_i;
        n_wr++;
      end else begin
        rdata_o <= mem.exists(addr_i) ? mem[addr_i] : (addr_i[31:0] ^ 32'h5A5A_0000);
        rd_log[n_rd] = addr_i;
        n_rd++;
      end
    end
  end
endmodule

// >>> verif/pcc_props.sv
/*
 Port-timing assertions for pcc_top.
 Assumes a bind from the bench top file.
*/
`timescale 1ns/1ps

module pcc_props (
  input wire        MCLK_I,
  input wire        RST_N_I,
  input wire [3:0]  AVS_ADDRESS_I,
  input wire        AVS_READ_I,
  input wire        AVS_WRITE_I,
  input wire        AVS_WAITREQUEST_O,
  input wire        PIPE_REQ_I,
  input wire        PIPE_STALL_O,
  input wire        MEM_REQ_O,
  input wire        MEM_WE_O,
  input wire [35:0] MEM_ADDR_O,
  input wire [31:0] MEM_WDATA_O,
  input wire        MEM_ACK_I
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////
  a_mem_hold: assert property (MEM_REQ_O && !MEM_ACK_I |=>
    MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_WE_O)) else $error("memory request moved");
  a_wdata_hold: assert property (MEM_REQ_O && MEM_WE_O && !MEM_ACK_I |=>
    $stable(MEM_WDATA_O)) else $error("write data moved before ack");
  a_rd_wait: assert property ($rose(AVS_READ_I) |->
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("read not answered after one wait");
  a_wr_nowait: assert property (AVS_WRITE_I && AVS_ADDRESS_I != 4'h2 |->
    !AVS_WAITREQUEST_O) else $error("plain write stalled");
  a_stall_idle: assert property (PIPE_REQ_I && !PIPE_STALL_O |-> !MEM_REQ_O)
    else $error("pipeline released with memory traffic pending");
  a_fill_stall: assert property (PIPE_REQ_I && MEM_REQ_O && !MEM_WE_O |-> PIPE_STALL_O)
    else $error("pipeline released during memory read");
  a_look_stall: assert property ($rose(PIPE_REQ_I) |-> PIPE_STALL_O)
    else $error("request not stalled for lookup");
  a_reset_quiet: assert property ($rose(RST_N_I) |-> !MEM_REQ_O && !PIPE_STALL_O)
    else $error("activity right after reset");
endmodule

// >>> verif/tb_primary_cache_control.sv
/*
 Bench for pcc_top: a table of pipeline accesses, then cache operations
 and a mid-run reset. Assumes pcc_mem_model on the memory port.
*/
`timescale 1ns/1ps

module tb_primary_cache_control;
  typedef struct {logic [3:0] c; logic d, w, k; logic [35:0] a; logic [31:0] v; int nr, nw;}
    pcc_row_t;
  logic        mclk = 0;
  logic        rst_n = 0;
  logic        av_r = 0, av_w = 0, p_req = 0, p_d = 0, p_w = 0;
  logic [3:0]  av_a = 0;
  logic [31:0] av_wd = 0, p_wd = 0, q;
  logic [35:0] p_a = 0;
  wire  [31:0] av_q, p_rd, m_wd, m_rd;
  wire  [35:0] m_a;
  wire         av_wait, p_stall, m_req, m_we, m_ack;
  int          fails = 0, n_compared = 0, cyc = 0, br, bw;
  pcc_row_t    rows [17] = '{
    '{0, 1, 0, 1, 36'h1000, 32'h5A5A_1000, 4, 0},
    '{0, 1, 0, 1, 36'h1008, 32'h5A5A_1008, 0, 0},
    '{0, 1, 1, 0, 36'h1008, 32'h1234_5678, 0, 0},
    '{0, 1, 0, 1, 36'h1008, 32'h1234_5678, 0, 0},
    '{2, 1, 0, 1, 36'h1000, 32'h5A5A_1000, 1, 0},
    '{2, 1, 1, 0, 36'h1008, 32'h0BAD_0BAD, 0, 1},
    '{0, 1, 0, 1, 36'h1008, 32'h1234_5678, 0, 0},
    '{1, 0, 0, 1, 36'h4000, 32'h5A5A_4000, 1, 0},
    '{0, 0, 0, 1, 36'h4000, 32'h5A5A_4000, 4, 0},
    '{0, 0, 0, 1, 36'h4008, 32'h5A5A_4008, 0, 0},
    '{4, 1, 1, 0, 36'h1000, 32'h0000_BEEF, 0, 1},
    '{0, 1, 0, 1, 36'h1000, 32'h0000_BEEF, 0, 0},
    '{0, 1, 0, 0, 36'h3000, 0, 4, 0},
    '{0, 1, 0, 0, 36'h5000, 0, 4, 0},
    '{0, 1, 0, 0, 36'h7000, 0, 4, 0},
    '{0, 1, 0, 0, 36'h9000, 0, 4, 4},
    '{0, 1, 0, 1, 36'h1008, 32'h1234_5678, 4, 0}};

  pcc_top dut (.MCLK_I(mclk), .RST_N_I(rst_n), .AVS_ADDRESS_I(av_a), .AVS_READ_I(av_r),
    .AVS_WRITE_I(av_w), .AVS_WRITEDATA_I(av_wd), .AVS_READDATA_O(av_q),
    .AVS_WAITREQUEST_O(av_wait), .PIPE_REQ_I(p_req), .PIPE_DSEL_I(p_d), .PIPE_WE_I(p_w),
    .PIPE_ADDR_I(p_a), .PIPE_WDATA_I(p_wd), .PIPE_RDATA_O(p_rd), .PIPE_STALL_O(p_stall),
    .MEM_REQ_O(m_req), .MEM_WE_O(m_we), .MEM_ADDR_O(m_a), .MEM_WDATA_O(m_wd),
    .MEM_ACK_I(m_ack), .MEM_RDATA_I(m_rd));
  pcc_mem_model mem (.clk_i(mclk), .rst_n_i(rst_n), .req_i(m_req), .we_i(m_we),
    .addr_i(m_a), .wdata_i(m_wd), .ack_o(m_ack), .rdata_o(m_rd));

  always #10 mclk = ~mclk;
  ////////////////////////////////////////
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    av_a  <= a;
    av_wd <= d;
    av_w  <= 1'b1;
    do @(posedge mclk); while (av_wait !== 1'b0);
    av_w <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    av_a <= a;
    av_r <= 1'b1;
    do @(posedge mclk); while (av_wait !== 1'b0);
    d = av_q;
    av_r <= 1'b0;
  endtask

  // Start a cache operation, wait for its done flag, then clear it
  task op(input logic [4:0] c, input logic [35:0] a);
    int i;
    wr(4'h3, a[31:0]);
    wr(4'h2, {27'h0, c});
    for (i = 0; i < 100; i++) begin
      rd(4'h4, q);
      if (q[6] === 1'b1) break;
    end
    chk({31'h0, q[6]}, 32'h0000_0001);
    wr(4'h5, 32'h0);
  endtask

  task acc(input pcc_row_t r);
    wr(4'h0, {28'h0, r.c});
    br = mem.n_rd;
    bw = mem.n_wr;
    @(posedge mclk);
    p_d   <= r.d;
    p_w   <= r.w;
    p_a   <= r.a;
    p_wd  <= r.v;
    p_req <= 1'b1;
    do @(posedge mclk); while (p_stall !== 1'b0);
    p_req <= 1'b0;
    if (r.k) chk(p_rd, r.v);
    while (m_req !== 1'b0) @(posedge mclk);
    chk(mem.n_rd - br, r.nr);
    chk(mem.n_wr - bw, r.nw);
    if (r.nr == 4) begin
      chk(32'(mem.rd_log[br][4:0]), 0);
      for (int j = 1; j < 4; j++) chk(32'(mem.rd_log[br + j] > mem.rd_log[br + j - 1]), 1);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) acc(rows[i]);
    acc('{0, 1, 1, 0, 36'h5008, 32'h7777_0001, 0, 0});
    bw = mem.n_wr;
    op(5'h17, 36'h5008);
    chk(mem.n_wr - bw, 4);
    acc('{0, 1, 0, 1, 36'h5008, 32'h7777_0001, 0, 0});
    acc('{0, 1, 1, 0, 36'h5008, 32'h7777_0002, 0, 0});
    bw = mem.n_wr;
    op(5'h15, 36'h5008);
    chk(mem.n_wr - bw, 4);
    acc('{0, 1, 0, 1, 36'h5008, 32'h7777_0002, 4, 0});
    wr(4'h0, 32'h0000_0002);
    op(5'h14, 36'hB000);
    op(5'h14, 36'h9000);
    acc('{0, 1, 0, 0, 36'h7000, 0, 0, 0});
    acc('{0, 1, 0, 0, 36'h9000, 0, 4, 0});
    wr(4'h1, 32'h0C00_0ABC);
    op(5'h12, 36'h200);
    wr(4'h1, 32'h0000_0000);
    op(5'h11, 36'h200);
    rd(4'h1, q);
    chk(q, 32'h0C00_0ABC);
    acc('{0, 1, 0, 0, 36'hAB_C200, 0, 0, 0});
    op(5'h00, 36'h4000);
    acc('{0, 0, 0, 0, 36'h4008, 0, 4, 0});
    acc('{0, 1, 1, 0, 36'h1004, 32'h1111_2222, 0, 0});
    acc('{0, 1, 1, 0, 36'hB008, 32'h2222_3333, 4, 4});
    acc('{0, 1, 0, 1, 36'hB008, 32'h2222_3333, 0, 0});
    acc('{0, 1, 0, 1, 36'h1004, 32'h1111_2222, 4, 0});
    br = mem.n_rd;
    op(5'h16, 36'hD000);
    chk(mem.n_rd - br, 4);
    acc('{0, 1, 0, 1, 36'hD004, 32'h5A5A_D004, 0, 0});
    bw = mem.n_wr;
    op(5'h13, 36'hF000);
    op(5'h13, 36'h1_1000);
    chk(mem.n_wr - bw, 4);
    acc('{0, 1, 0, 0, 36'h1_1000, 0, 0, 0});
    bw = mem.n_wr;
    op(5'h18, 36'h1000);
    chk(mem.n_wr - bw, 4);
    acc('{0, 1, 0, 1, 36'hB008, 32'h2222_3333, 4, 0});
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, q);
    chk(q, 32'h0000_0000);
    rd(4'hF, q);
    chk(q, 32'h0000_0000);
    acc('{0, 1, 0, 1, 36'h1008, 32'h1234_5678, 4, 0});
    end_sim;
  end
endmodule

bind pcc_top pcc_props chk_i (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PIPE_REQ_I(PIPE_REQ_I), .PIPE_STALL_O(PIPE_STALL_O),
  .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_WDATA_O(MEM_WDATA_O), .MEM_ACK_I(MEM_ACK_I));
